// ===== hdl/hes_pkg.sv
// Constants shared by the exposure sequencer and its register bank
package hes_pkg;
	// Register byte addresses
	localparam logic [6:0] ADDR_EXP_SOURCE = 7'h29;
	localparam logic [6:0] ADDR_TOTAL_EXP = 7'h2a;
	localparam logic [6:0] ADDR_EXP_INC = 7'h2d;
	localparam logic [6:0] ADDR_KNEE_ONE = 7'h30;
	localparam logic [6:0] ADDR_KNEE_TWO = 7'h33;
	localparam logic [6:0] ADDR_SLOPE_COUNT = 7'h36;
	localparam logic [6:0] ADDR_FRAME_SEQ_LEN = 7'h37;
	localparam logic [6:0] ADDR_OVERHEAD_LEN = 7'h49;
	localparam logic [6:0] ADDR_CLIP_TWO = 7'h59;
	localparam logic [6:0] ADDR_CLIP_THREE = 7'h5a;
	// Reset values
	localparam logic [23:0] RST_TOTAL_EXP = 24'h000440;
	localparam logic [23:0] RST_EXP_INC = 24'h000000;
	localparam logic [23:0] RST_KNEE = 24'h000001;
	localparam logic [7:0] RST_SLOPE_COUNT = 8'h01;
	localparam logic [7:0] RST_FRAME_SEQ_LEN = 8'h01;
	localparam logic [7:0] RST_OVERHEAD_LEN = 8'h0a;
	localparam logic [7:0] RST_CLIP = 8'h60;
	localparam logic [7:0] RST_EXP_SOURCE = 8'h00;
	// Write masks of the narrow registers
	localparam logic [7:0] MASK_SLOPE_COUNT = 8'h03;
	localparam logic [7:0] MASK_CLIP = 8'h7f;
	localparam logic [7:0] MASK_EXP_SOURCE = 8'h01;
	// Clip level field layout
	localparam int CLIP_EN_BIT = 6;
	localparam int CLIP_CODE_MSB = 5;
	// Timing: one unit is 129 clocks, overhead weight 0.43 kept as 43/100
	localparam logic [7:0] UNIT_CYCLES = 8'h81;
	localparam logic [7:0] HUNDREDTH_STEP = 8'h64;
	localparam logic [31:0] OVH_NUM = 32'h0000002b;
	localparam logic [31:0] SCALE = 32'h00000064;
endpackage : hes_pkg

// ===== hdl/hes_regbank.sv
// Byte-wide register bank of the exposure sequencer
`timescale 1ns/10ps
module hes_regbank (
	input wire logic clock, // 100 MHz clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [6:0] reg_addr, // Byte address
	input wire logic [7:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	output logic [7:0] reg_rdata, // Registered read data
	output logic exp_source, // 1: pin-timed exposure
	output logic [23:0] total_exposure_value, // Base exposure
	output logic [23:0] exposure_increment, // Per-frame step
	output logic [23:0] knee_one_exposure, // Knee one interval
	output logic [23:0] knee_two_exposure, // Knee two interval
	output logic [1:0] response_slope_count, // Slopes 1..3
	output logic [7:0] frame_sequence_length, // Frames per sequence
	output logic [7:0] overhead_length, // Frame overhead length
	output logic [6:0] second_clip_level, // Enable and code
	output logic [6:0] third_clip_level // Enable and code
);
	typedef struct packed {
		logic [127:0][7:0] mem;
		logic [7:0] rdata;
	} hes_bank_t;
	hes_bank_t s_q, s_d;

	// Reset value and write mask per byte; unmapped bytes stay zero
	function automatic logic [15:0] hes_cfg(input logic [6:0] a);
		logic [15:0] r;
		r = 16'h0000;
		if (a == hes_pkg::ADDR_EXP_SOURCE) begin
			r = {hes_pkg::MASK_EXP_SOURCE, hes_pkg::RST_EXP_SOURCE};
		end else if (a >= hes_pkg::ADDR_TOTAL_EXP && a < hes_pkg::ADDR_EXP_INC) begin
			r = {8'hff, hes_pkg::RST_TOTAL_EXP[8*(a-hes_pkg::ADDR_TOTAL_EXP) +: 8]};
		end else if (a >= hes_pkg::ADDR_EXP_INC && a < hes_pkg::ADDR_KNEE_ONE) begin
			r = {8'hff, hes_pkg::RST_EXP_INC[8*(a-hes_pkg::ADDR_EXP_INC) +: 8]};
		end else if (a >= hes_pkg::ADDR_KNEE_ONE && a < hes_pkg::ADDR_KNEE_TWO) begin
			r = {8'hff, hes_pkg::RST_KNEE[8*(a-hes_pkg::ADDR_KNEE_ONE) +: 8]};
		end else if (a >= hes_pkg::ADDR_KNEE_TWO && a < hes_pkg::ADDR_SLOPE_COUNT) begin
			r = {8'hff, hes_pkg::RST_KNEE[8*(a-hes_pkg::ADDR_KNEE_TWO) +: 8]};
		end else if (a == hes_pkg::ADDR_SLOPE_COUNT) begin
			r = {hes_pkg::MASK_SLOPE_COUNT, hes_pkg::RST_SLOPE_COUNT};
		end else if (a == hes_pkg::ADDR_FRAME_SEQ_LEN) begin
			r = {8'hff, hes_pkg::RST_FRAME_SEQ_LEN};
		end else if (a == hes_pkg::ADDR_OVERHEAD_LEN) begin
			r = {8'hff, hes_pkg::RST_OVERHEAD_LEN};
		end else if (a == hes_pkg::ADDR_CLIP_TWO || a == hes_pkg::ADDR_CLIP_THREE) begin
			r = {hes_pkg::MASK_CLIP, hes_pkg::RST_CLIP};
		end
		return r;
	endfunction : hes_cfg

	// Write mask of one byte; a call result cannot be sliced in place
	function automatic logic [7:0] hes_mask(input logic [6:0] a);
		logic [15:0] c;
		c = hes_cfg(a);
		return c[15:8];
	endfunction : hes_mask

	// Reset value of one byte
	function automatic logic [7:0] hes_rst(input logic [6:0] a);
		logic [15:0] c;
		c = hes_cfg(a);
		return c[7:0];
	endfunction : hes_rst

	// Masked byte writes, read data registered from the addressed byte
	always_comb begin
		s_d = s_q;
		if (reg_wr) begin
			s_d.mem[reg_addr] = reg_wdata & hes_mask(reg_addr);
		end
		s_d.rdata = s_q.mem[reg_addr];
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 128; i++) begin
				s_q.mem[i] <= hes_rst(7'(i));
			end
			s_q.rdata <= 8'h00;
		end else begin
			s_q <= s_d;
		end
	end

	assign total_exposure_value = {s_q.mem[hes_pkg::ADDR_TOTAL_EXP + 7'h02],
		s_q.mem[hes_pkg::ADDR_TOTAL_EXP + 7'h01], s_q.mem[hes_pkg::ADDR_TOTAL_EXP]};
	assign exposure_increment = {s_q.mem[hes_pkg::ADDR_EXP_INC + 7'h02],
		s_q.mem[hes_pkg::ADDR_EXP_INC + 7'h01], s_q.mem[hes_pkg::ADDR_EXP_INC]};
	assign knee_one_exposure = {s_q.mem[hes_pkg::ADDR_KNEE_ONE + 7'h02],
		s_q.mem[hes_pkg::ADDR_KNEE_ONE + 7'h01], s_q.mem[hes_pkg::ADDR_KNEE_ONE]};
	assign knee_two_exposure = {s_q.mem[hes_pkg::ADDR_KNEE_TWO + 7'h02],
		s_q.mem[hes_pkg::ADDR_KNEE_TWO + 7'h01], s_q.mem[hes_pkg::ADDR_KNEE_TWO]};
	// Narrow fields
	assign exp_source = s_q.mem[hes_pkg::ADDR_EXP_SOURCE][0];
	assign response_slope_count = s_q.mem[hes_pkg::ADDR_SLOPE_COUNT][1:0];
	assign frame_sequence_length = s_q.mem[hes_pkg::ADDR_FRAME_SEQ_LEN];
	assign overhead_length = s_q.mem[hes_pkg::ADDR_OVERHEAD_LEN];
	assign second_clip_level = s_q.mem[hes_pkg::ADDR_CLIP_TWO][6:0];
	assign third_clip_level = s_q.mem[hes_pkg::ADDR_CLIP_THREE][6:0];
	assign reg_rdata = s_q.rdata;
endmodule : hes_regbank

// ===== hdl/hes_sequencer.sv
// HDR exposure sequencer: piecewise knee timing and multi-frame exposure
//
// Function
// - Internal exposure lasts 129 clocks times (0.43*overhead plus total value).
// - Slope count selects one to three slopes; resets to one.
// - Knee one interval is 129 clocks times (0.43*overhead plus knee one).
// - Knee two interval is 129 clocks times (0.43*overhead plus knee two).
// - Third clip level: bit 6 enables, bits 5..0 DAC code, reset 96.
// - Second clip level: bit 6 enables, bits 5..0 DAC code, reset 96.
// - External mode: slopes and clips from registers, timing from the pins.
// - First multi-frame exposure uses the base total exposure value.
// - Frame n adds n minus one increments to the base value.
// - Sequence length 1..255 frames, reset one, host never writes zero.
// - Each multi-frame exposure is reported as a frame of its own.
// - Source select clear: register timing; set: start pin to request pin.
// - Clip level is applied at most twice per exposure.
// - Clip codes place knee points, knee intervals set segment slopes.
`timescale 1ns/10ps
module hes_sequencer (
	input wire logic clock, // 100 MHz clock
	input wire logic arst_n, // Async reset, active low
	input wire logic [6:0] reg_addr, // Register byte address
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Register write strobe
	output logic [7:0] reg_rdata, // Registered read data
	input wire logic exposure_start_pin, // Exposure start pin, async
	input wire logic frame_request_pin, // Frame request pin, async
	output logic exposing, // High while pixels integrate
	output logic clip_pulse, // One cycle: apply clip level
	output logic [5:0] clip_code, // DAC code for the clip
	output logic frame_done, // One cycle: exposure finished
	output logic [7:0] frame_index // Number of finished frame
);
	typedef enum logic [1:0] {ST_IDLE, ST_EXPOSE, ST_OVERHEAD} hes_state_t;
	typedef struct packed {
		hes_state_t st;
		logic start_a, start_b, start_prev;
		logic req_a, req_b, req_prev;
		logic ext_run;
		logic [7:0] phase;
		logic [31:0] elapsed;
		logic [31:0] target;
		logic [23:0] cur_val;
		logic [7:0] frame_cnt;
		logic [1:0] knee_done;
		logic exposing, clip_pulse, frame_done;
		logic [5:0] clip_code;
		logic [7:0] frame_index;
	} hes_seq_t;
	hes_seq_t s_q, s_d;

	logic exp_source, start_rise, req_rise, tick;
	logic [23:0] total_val, inc_val, k1_val, k2_val;
	logic [1:0] slopes_raw, slopes;
	logic [7:0] seq_len, ovh_len;
	logic [6:0] clip_two, clip_three;
	logic [31:0] ovh, k1_t, k2_t, s1, s2, tot_t;
	logic [8:0] phase_sum;

	hes_regbank u_bank (
		.clock(clock),
		.arst_n(arst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rdata(reg_rdata),
		.exp_source(exp_source),
		.total_exposure_value(total_val),
		.exposure_increment(inc_val),
		.knee_one_exposure(k1_val),
		.knee_two_exposure(k2_val),
		.response_slope_count(slopes_raw),
		.frame_sequence_length(seq_len),
		.overhead_length(ovh_len),
		.second_clip_level(clip_two),
		.third_clip_level(clip_three)
	);

	assign slopes = (slopes_raw == 2'h0) ? 2'h1 : slopes_raw;
	// Durations in hundredths of a 129-clock unit, so 0.43 stays exact
	assign ovh = hes_pkg::OVH_NUM * {24'h000000, ovh_len};
	assign k1_t = ovh + hes_pkg::SCALE * {8'h00, k1_val};
	assign k2_t = ovh + hes_pkg::SCALE * {8'h00, k2_val};
	assign tot_t = ovh + hes_pkg::SCALE * {8'h00, s_q.cur_val};
	// knee starts: internal from end backward, external from start forward
	always_comb begin
		s1 = 32'h00000000;
		s2 = 32'h00000000;
		if (s_q.ext_run) begin
			s1 = k1_t;
			s2 = k1_t + k2_t;
		end else if (slopes == 2'h3) begin
			s2 = (tot_t > k2_t) ? tot_t - k2_t : 32'h00000000;
			s1 = (s2 > k1_t) ? s2 - k1_t : 32'h00000000;
		end else begin
			s1 = (tot_t > k1_t) ? tot_t - k1_t : 32'h00000000;
		end
	end
	// Edge detect only on second sync stage
	assign start_rise = s_q.start_b & ~s_q.start_prev;
	assign req_rise = s_q.req_b & ~s_q.req_prev;
	// Fractional divider: each clock is 100/129 hundredths of a unit
	assign phase_sum = {1'b0, s_q.phase} + {1'b0, hes_pkg::HUNDREDTH_STEP};
	assign tick = (phase_sum >= {1'b0, hes_pkg::UNIT_CYCLES});

	// Next-state logic of the whole sequencer
	always_comb begin
		s_d = s_q;
		s_d.start_a = exposure_start_pin;
		s_d.start_b = s_q.start_a;
		s_d.start_prev = s_q.start_b;
		s_d.req_a = frame_request_pin;
		s_d.req_b = s_q.req_a;
		s_d.req_prev = s_q.req_b;
		s_d.clip_pulse = 1'b0;
		s_d.frame_done = 1'b0;
		s_d.phase = tick ? 8'(phase_sum - {1'b0, hes_pkg::UNIT_CYCLES}) : phase_sum[7:0];
		s_d.elapsed = s_q.elapsed + {31'h0, tick};
		case (s_q.st)
			ST_IDLE: begin
				s_d.phase = 8'h00;
				s_d.elapsed = 32'h00000000;
				s_d.knee_done = 2'b00;
				s_d.frame_cnt = 8'h01;
				s_d.cur_val = total_val;
				if (exp_source && start_rise) begin
					s_d.st = ST_EXPOSE;
					s_d.ext_run = 1'b1;
					s_d.exposing = 1'b1;
				end else if (!exp_source && req_rise) begin
					s_d.st = ST_EXPOSE;
					s_d.ext_run = 1'b0;
					s_d.exposing = 1'b1;
					s_d.target = ovh + hes_pkg::SCALE * {8'h00, total_val};
				end
			end
			ST_EXPOSE: begin
				if (slopes >= 2'h2 && !s_q.knee_done[0] && s_q.elapsed >= s1) begin
					s_d.knee_done[0] = 1'b1;
					s_d.clip_pulse = clip_two[hes_pkg::CLIP_EN_BIT];
					s_d.clip_code = clip_two[hes_pkg::CLIP_CODE_MSB:0];
				end else if (slopes == 2'h3 && s_q.knee_done == 2'b01 && s_q.elapsed >= s2) begin
					s_d.knee_done[1] = 1'b1;
					s_d.clip_pulse = clip_three[hes_pkg::CLIP_EN_BIT];
					s_d.clip_code = clip_three[hes_pkg::CLIP_CODE_MSB:0];
				end
				if (s_q.ext_run) begin
					if (req_rise) begin
						s_d.st = ST_OVERHEAD;
						s_d.exposing = 1'b0;
						s_d.elapsed = 32'h00000000;
						s_d.phase = 8'h00;
						s_d.target = ovh;
					end
				end else if (s_q.elapsed >= s_q.target) begin
					s_d.frame_done = 1'b1;
					s_d.frame_index = s_q.frame_cnt;
					s_d.elapsed = 32'h00000000;
					s_d.phase = 8'h00;
					s_d.knee_done = 2'b00;
					if (s_q.frame_cnt < seq_len) begin
						s_d.cur_val = s_q.cur_val + inc_val;
						s_d.target = ovh + hes_pkg::SCALE * {8'h00, s_q.cur_val + inc_val};
						s_d.frame_cnt = s_q.frame_cnt + 8'h01;
					end else begin
						s_d.st = ST_IDLE;
						s_d.exposing = 1'b0;
					end
				end
			end
			ST_OVERHEAD: begin
				if (s_q.elapsed >= s_q.target) begin
					s_d.frame_done = 1'b1;
					s_d.frame_index = 8'h01;
					s_d.st = ST_IDLE;
				end
			end
			default: begin
				s_d.st = ST_IDLE;
			end
		endcase
	end

	// Register the whole state
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign exposing = s_q.exposing;
	assign clip_pulse = s_q.clip_pulse;
	assign clip_code = s_q.clip_code;
	assign frame_done = s_q.frame_done;
	assign frame_index = s_q.frame_index;

	property p_idle_dark;
		@(posedge clock) disable iff (!arst_n)
		(s_q.st == ST_IDLE) |-> !s_q.exposing;
	endproperty
	a_idle_dark: assert property (p_idle_dark) else $error("exposing while idle");

	property p_phase_range;
		@(posedge clock) disable iff (!arst_n)
		s_q.phase < hes_pkg::UNIT_CYCLES;
	endproperty
	a_phase_range: assert property (p_phase_range) else $error("divider phase overflow");

	property p_int_length;
		@(posedge clock) disable iff (!arst_n)
		(s_q.frame_done && !s_q.ext_run) |-> $past(s_q.elapsed) >= $past(s_q.target);
	endproperty
	a_int_length: assert property (p_int_length) else $error("frame ended early");

	property p_step_add;
		@(posedge clock) disable iff (!arst_n)
		(s_q.frame_done && s_q.st == ST_EXPOSE && $stable(inc_val))
			|-> s_q.cur_val == 24'($past(s_q.cur_val) + inc_val);
	endproperty
	a_step_add: assert property (p_step_add) else $error("increment not applied");

	property p_seq_bound;
		@(posedge clock) disable iff (!arst_n)
		(s_q.frame_done && !s_q.ext_run && $stable(seq_len)) |-> s_q.frame_index <= seq_len;
	endproperty
	a_seq_bound: assert property (p_seq_bound) else $error("too many frames");

	property p_clip_slopes;
		@(posedge clock) disable iff (!arst_n)
		s_q.clip_pulse |-> $past(slopes) >= 2'h2;
	endproperty
	a_clip_slopes: assert property (p_clip_slopes) else $error("clip with one slope");

	property p_clip_two_code;
		@(posedge clock) disable iff (!arst_n)
		(s_q.clip_pulse && s_q.knee_done == 2'b01) |-> s_q.clip_code == $past(clip_two[5:0]);
	endproperty
	a_clip_two_code: assert property (p_clip_two_code) else $error("wrong second code");

	property p_clip_three_code;
		@(posedge clock) disable iff (!arst_n)
		(s_q.clip_pulse && s_q.knee_done == 2'b11) |-> s_q.clip_code == $past(clip_three[5:0]);
	endproperty
	a_clip_three_code: assert property (p_clip_three_code) else $error("wrong third code");

	property p_ext_start;
		@(posedge clock) disable iff (!arst_n)
		(s_q.st == ST_IDLE && exp_source && start_rise) |=> (s_q.st == ST_EXPOSE && s_q.ext_run);
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("pin start missed");
endmodule : hes_sequencer

// ===== test/hes_host_model.sv
// Host controller model: byte writes and reads, exposure pins
`timescale 1ns/10ps
module hes_host_model (
	input wire logic clock, // Sequencer clock
	input wire logic [7:0] reg_rdata, // Read data from device
	output logic [6:0] reg_addr, // Byte address
	output logic [7:0] reg_wdata, // Write data
	output logic reg_wr, // Write strobe
	output logic exposure_start_pin, // Starts pin-timed exposure
	output logic frame_request_pin // Starts or ends exposure
);
	logic [7:0] seq_len_q = 8'h01; // Shadow of the sequence length

	// Quiet bus and pins from time zero
	initial begin
		reg_addr = 7'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		exposure_start_pin = 1'b0;
		frame_request_pin = 1'b0;
	end

	// One byte per strobe; held over exactly one sampling edge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (a == 7'h29) v = d & 8'h01;
		if (a == 7'h36 && v[1:0] == 2'b00) v = 8'h01;
		if (a == 7'h37 && v == 8'h00) v = 8'h01;
		if (a == 7'h37) seq_len_q = v;
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge clock);
		#1;
		reg_wr = 1'b0;
	endtask : wr

	task automatic wr24(input logic [6:0] a, input logic [23:0] v);
		for (int i = 0; i < 3; i++) begin
			wr(a + 7'(i), v[8*i +: 8]);
		end
	endtask : wr24

	// Read data is registered: taken one edge after the address
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clock);
		#1;
		reg_addr = a;
		@(posedge clock);
		#1;
		d = reg_rdata;
	endtask : rd

	task automatic pulse_start();
		if (seq_len_q != 8'h01) return;
		@(posedge clock);
		#1;
		exposure_start_pin = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		exposure_start_pin = 1'b0;
	endtask : pulse_start

	task automatic pulse_req();
		@(posedge clock);
		#1;
		frame_request_pin = 1'b1;
		repeat (4) @(posedge clock);
		#1;
		frame_request_pin = 1'b0;
	endtask : pulse_req
endmodule : hes_host_model

// ===== test/testbench.sv
// Self-checking bench of the exposure sequencer
`timescale 1ns/10ps
module testbench;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, frame_index;
	logic reg_wr, exposure_start_pin, frame_request_pin, exposing, clip_pulse, frame_done;
	logic [5:0] clip_code;
	int mismatches = 0, tests_run = 0, cyc = 0, mark = 0, nfd = 0, nclip = 0, exp_hi = 0;
	logic [31:0] durs[$];
	int clip_at[$];
	logic [7:0] idxs[$];
	logic [5:0] codes[$];
	logic exp_prev = 1'b0;
	logic [6:0] ra [0:15] = '{7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h2f, 7'h30,
		7'h31, 7'h32, 7'h33, 7'h36, 7'h37, 7'h49, 7'h59, 7'h5a};
	logic [7:0] rv [0:15] = '{8'h00, 8'h40, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
		8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h0a, 8'h60, 8'h60};

	always #5 clock = ~clock;

	hes_host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .exposure_start_pin(exposure_start_pin),
		.frame_request_pin(frame_request_pin));

	hes_sequencer dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
		.exposure_start_pin(exposure_start_pin), .frame_request_pin(frame_request_pin),
		.exposing(exposing), .clip_pulse(clip_pulse), .clip_code(clip_code),
		.frame_done(frame_done), .frame_index(frame_index));

	// Sampled on the falling edge, where the registered outputs have settled
	always @(negedge clock) begin
		cyc++;
		if (exposing === 1'b1 && exp_prev !== 1'b1) mark = cyc;
		if (exposing === 1'b1) exp_hi++;
		if (clip_pulse === 1'b1) begin
			nclip++;
			codes.push_back(clip_code);
			clip_at.push_back(cyc - mark);
		end
		if (frame_done === 1'b1) begin
			durs.push_back(cyc - mark);
			idxs.push_back(frame_index);
			nfd++;
			mark = cyc;
		end
		exp_prev = exposing;
		if (cyc == 40000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks run %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
		tests_run++;
		if (seen !== expd) begin
			mismatches++;
			$display("mismatch %s expected %0h seen %0h", name, expd, seen);
		end
	endtask : check

	// Fractional divider may round either way by a cycle or two
	function automatic logic near(input logic [31:0] s, input logic [31:0] e);
		return (s + 4 >= e) && (s <= e + 4);
	endfunction : near

	function automatic logic [31:0] dur(input int f, input int v);
		return (129 * (43 * f + 100 * v) + 99) / 100 + 2;
	endfunction : dur

	task automatic clear();
		nfd = 0;
		nclip = 0;
		exp_hi = 0;
		durs.delete();
		idxs.delete();
		codes.delete();
		clip_at.delete();
	endtask : clear

	task automatic wait_frames(input int n);
		int g;
		g = 0;
		while (nfd < n && g < 5000) begin
			@(posedge clock);
			g++;
		end
		check("frames_done", nfd, n);
		repeat (4) @(posedge clock);
	endtask : wait_frames

	initial begin
		logic [7:0] d;
		repeat (12) @(posedge clock);
		#1;
		arst_n = 1'b1;
		// Reset values of every mapped byte except the upper two bytes of knee two
		for (int i = 0; i < 16; i++) begin
			host.rd(ra[i], d);
			check("reset_byte", d, rv[i]);
		end
		// Field widths, unmapped place, byte order
		host.wr(7'h36, 8'hff);
		host.rd(7'h36, d);
		check("slope_mask", d, 8'h03);
		host.wr(7'h5a, 8'hff);
		host.rd(7'h5a, d);
		check("clip3_mask", d, 8'h7f);
		host.wr(7'h00, 8'h55);
		host.rd(7'h00, d);
		check("unmapped", d, 8'h00);
		host.wr24(7'h2d, 24'h123456);
		for (int i = 0; i < 3; i++) begin
			host.rd(7'h2d + 7'(i), d);
			check("wide_byte", d, 8'(24'h123456 >> (8 * i)));
		end
		// Single internal frame with overhead term
		host.wr24(7'h2d, 24'h000000);
		host.wr(7'h49, 8'h02);
		host.wr24(7'h2a, 24'h000003);
		host.wr(7'h36, 8'h01);
		host.wr(7'h37, 8'h01);
		clear();
		host.pulse_req();
		wait_frames(1);
		check("frame_len", near(durs[0], dur(2, 3)), 1);
		check("frame_index", idxs[0], 8'h01);
		check("one_slope", nclip, 0);
		// Three-frame sequence with growing exposure
		host.wr(7'h49, 8'h00);
		host.wr24(7'h2a, 24'h000001);
		host.wr24(7'h2d, 24'h000002);
		host.wr(7'h37, 8'h03);
		clear();
		host.pulse_req();
		wait_frames(3);
		for (int i = 0; i < 3; i++) begin
			check("multi_len", near(durs[i], dur(0, 1 + 2 * i)), 1);
			check("multi_index", idxs[i], i + 1);
		end
		check("span", near(exp_hi, durs[0] + durs[1] + durs[2]), 1);
		// Three slopes: two clips in order
		host.wr24(7'h2d, 24'h000000);
		host.wr(7'h37, 8'h01);
		host.wr24(7'h2a, 24'h000004);
		host.wr24(7'h30, 24'h000001);
		host.wr24(7'h33, 24'h000001);
		host.wr(7'h59, 8'h45);
		host.wr(7'h5a, 8'h4a);
		host.wr(7'h36, 8'h03);
		clear();
		host.pulse_req();
		wait_frames(1);
		check("clip_count", nclip, 2);
		check("first_code", codes[0], 6'h05);
		check("second_code", codes[1], 6'h0a);
		// Knee value one with zero overhead: each knee lasts one 129-clock unit
		check("knee_two_len", near(durs[0] - clip_at[1], 129), 1);
		check("knee_one_len", near(clip_at[1] - clip_at[0], 129), 1);
		// Disabled level: code moves, no pulse
		host.wr(7'h59, 8'h07);
		host.wr(7'h36, 8'h02);
		clear();
		host.pulse_req();
		wait_frames(1);
		check("clip_off", nclip, 0);
		check("code_kept", clip_code, 6'h07);
		// Pin-timed exposure ignores the total value
		host.wr(7'h29, 8'h01);
		host.wr(7'h59, 8'h45);
		clear();
		host.pulse_start();
		repeat (296) @(posedge clock);
		host.pulse_req();
		wait_frames(1);
		check("pin_span", near(exp_hi, 301), 1);
		check("pin_clips", nclip, 1);
		check("pin_index", idxs[0], 8'h01);
		host.wr(7'h29, 8'h00);
		final_report();
	end
endmodule : testbench
